/* File: src/erf_pkg.sv */
// Summary of operation
// - Bad-checksum collect set: accept only packets whose checksum failed.
// - Good-checksum only set: accept only packets whose checksum passed.
// - Short-frame collect set: accept only packets that qualify as short.
// - Short means under 64 bytes, plus good checksum when good-only is set.
// - Short-frame reject set: refuse every packet under 64 bytes.
// - Station unicast set: accept unicast matching the station address.
// - Foreign unicast set: accept unicast not matching the station address.
// - Multicast set: accept every multicast destination packet except broadcast.
// - Broadcast set: accept every broadcast destination packet.
// - Hash match counts whatever the hash filter enable says.
// - Wake-frame match counts whatever the wake filter enable says.
// - Settings act on the receive path only; transmit untouched.
package erf_pkg;
  localparam logic [11:0] ERF_ADDR_RXFC   = 12'h0000;
  localparam logic [11:0] ERF_ADDR_CTRL   = 12'h0004;
  localparam logic [11:0] ERF_ADDR_STA_LO = 12'h0008;
  localparam logic [11:0] ERF_ADDR_STA_HI = 12'h000C;
  localparam logic [11:0] ERF_ADDR_ACCCNT = 12'h0010;
  localparam logic [11:0] ERF_ADDR_REJCNT = 12'h0014;
  localparam logic [11:0] ERF_ADDR_STATUS = 12'h0018;

  localparam int ERF_BIT_BADCRC  = 7;
  localparam int ERF_BIT_GOODCRC = 6;
  localparam int ERF_BIT_RUNTCOL = 5;
  localparam int ERF_BIT_RUNTREJ = 4;
  localparam int ERF_BIT_UC      = 3;
  localparam int ERF_BIT_NOTME   = 2;
  localparam int ERF_BIT_MC      = 1;
  localparam int ERF_BIT_BC      = 0;
  localparam int ERF_BIT_HASH_FILTER_ENABLE    = 9;
  localparam int ERF_BIT_WAKE_FRAME_FILTER_ENABLE    = 8;
  localparam int ERF_BIT_RECEIVE_ENABLE    = 8;

  localparam logic [15:0] ERF_RUNT_BYTES = 16'h0040;
  localparam logic [31:0] ERF_RXFC_RST   = 32'h0000_0000;
  localparam logic [31:0] ERF_RXFC_MASK  = 32'h0000_03FF;
  localparam logic [47:0] ERF_BCAST      = 48'hFFFF_FFFF_FFFF;
  localparam int ERF_FIFO_DEPTH = 4;

  typedef struct packed {
    logic [47:0] dest;
    logic [15:0] length;
    logic        crc_ok;
    logic        hash_hit;
    logic        wake_hit;
  } erf_desc_t;

  typedef struct packed {
    logic        accept;
    logic [15:0] length;
  } erf_verdict_t;
endpackage

/* File: src/erf_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module erf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             in_ready_reg;
  logic             push;
  logic             pop;

  // Registered so the ready output comes straight from a flop
  assign in_ready  = in_ready_reg;
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  always_comb
  begin
    count_next = count_reg;
    if (push && !pop)
      count_next = count_reg + 1'b1;
    else if (pop && !push)
      count_next = count_reg - 1'b1;
  end

  always_ff @(posedge pclk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready_reg <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= bump(wr_ptr_reg);
      if (pop)
        rd_ptr_reg <= bump(rd_ptr_reg);
      count_reg    <= count_next;
      in_ready_reg <= (count_next != (AW+1)'(DEPTH));
    end
  end
endmodule
`default_nettype wire

/* File: src/erf_filter.sv */
`timescale 1ns/1ns
`default_nettype none
module erf_filter
  import erf_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        desc_valid,
  output logic             desc_ready,
  input  wire erf_desc_t   desc,
  output logic             verdict_valid,
  input  wire logic        verdict_ready,
  output erf_verdict_t     verdict,
  output logic             receive_enable
);
  logic [31:0]  receive_filter_config_reg;
  logic [31:0]  mac_main_control_reg;
  logic [47:0]  station_addr_reg;
  logic [31:0]  accept_count_reg;
  logic [31:0]  reject_count_reg;
  logic [31:0]  prdata_reg;
  logic         pready_reg;
  logic         pslverr_reg;
  logic         verdict_valid_reg;
  erf_verdict_t verdict_reg;
  logic         cfg_write_refused_reg;
  logic         receive_enable_reg;

  logic         fifo_in_ready;
  logic         fifo_out_valid;
  logic         fifo_out_ready;
  erf_desc_t    fifo_out;
  logic         acc_next;
  logic         apb_access;
  logic         apb_wr;
  logic         known;

  erf_fifo #(
    .WIDTH ($bits(erf_desc_t)),
    .DEPTH (ERF_FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (desc_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (desc),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  // Back-pressure straight from the queue
  assign desc_ready = fifo_in_ready;

  // Receive on, and verdict slot free or being drained this cycle
  assign fifo_out_ready = receive_enable_reg && (!verdict_valid_reg || verdict_ready);

  function automatic logic decide(input erf_desc_t d, input logic [31:0] c,
                                  input logic [47:0] sta);
    logic runt;
    logic mcast;
    logic bcast;
    logic ucast;
    logic qual;
    logic hit;
    runt  = (d.length < ERF_RUNT_BYTES);
    bcast = (d.dest == ERF_BCAST);
    // Group bit is the first bit on the wire of the first octet
    mcast = d.dest[40] && !bcast;
    ucast = !d.dest[40];
    qual  = 1'b1;
    if (c[ERF_BIT_BADCRC] && d.crc_ok)
      qual = 1'b0;
    if (c[ERF_BIT_GOODCRC] && !d.crc_ok)
      qual = 1'b0;
    if (c[ERF_BIT_RUNTCOL] && !(runt && (d.crc_ok || !c[ERF_BIT_GOODCRC])))
      qual = 1'b0;
    if (c[ERF_BIT_RUNTREJ] && runt)
      qual = 1'b0;
    hit = 1'b0;
    if (c[ERF_BIT_UC] && ucast && d.dest == sta)
      hit = 1'b1;
    if (c[ERF_BIT_NOTME] && ucast && d.dest != sta)
      hit = 1'b1;
    if (c[ERF_BIT_MC] && mcast)
      hit = 1'b1;
    if (c[ERF_BIT_BC] && bcast)
      hit = 1'b1;
    if (d.hash_hit)
      hit = 1'b1;
    if (d.wake_hit)
      hit = 1'b1;
    decide = qual && hit;
  endfunction

  assign acc_next = decide(fifo_out, receive_filter_config_reg,
                           station_addr_reg);

  // Verdict stage, receive path only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      verdict_valid_reg <= 1'b0;
      verdict_reg       <= '0;
    end
    else if (fifo_out_valid && fifo_out_ready)
    begin
      verdict_valid_reg  <= 1'b1;
      verdict_reg.accept <= acc_next;
      verdict_reg.length <= fifo_out.length;
    end
    else if (verdict_ready)
    begin
      verdict_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      accept_count_reg <= '0;
      reject_count_reg <= '0;
    end
    else if (fifo_out_valid && fifo_out_ready)
    begin
      if (acc_next)
        accept_count_reg <= accept_count_reg + 1'b1;
      else
        reject_count_reg <= reject_count_reg + 1'b1;
    end
  end

  assign apb_access = psel && penable;
  assign apb_wr     = apb_access && pwrite;
  assign known = (paddr == ERF_ADDR_RXFC) || (paddr == ERF_ADDR_CTRL) ||
                 (paddr == ERF_ADDR_STA_LO) || (paddr == ERF_ADDR_STA_HI) ||
                 (paddr == ERF_ADDR_ACCCNT) || (paddr == ERF_ADDR_REJCNT) ||
                 (paddr == ERF_ADDR_STATUS);

  // Config writes honoured only while receive is off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      receive_filter_config_reg <= ERF_RXFC_RST;
      cfg_write_refused_reg     <= 1'b0;
    end
    else if (apb_wr && paddr == ERF_ADDR_RXFC)
    begin
      if (!receive_enable_reg)
        receive_filter_config_reg <= pwdata & ERF_RXFC_MASK;
      cfg_write_refused_reg <= receive_enable_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mac_main_control_reg <= '0;
      receive_enable_reg             <= 1'b0;
      station_addr_reg     <= '0;
    end
    else if (apb_wr)
    begin
      if (paddr == ERF_ADDR_CTRL)
      begin
        mac_main_control_reg <= pwdata & (32'h0000_0001 << ERF_BIT_RECEIVE_ENABLE);
        receive_enable_reg             <= pwdata[ERF_BIT_RECEIVE_ENABLE];
      end
      if (paddr == ERF_ADDR_STA_LO)
        station_addr_reg[31:0] <= pwdata;
      if (paddr == ERF_ADDR_STA_HI)
        station_addr_reg[47:32] <= pwdata[15:0];
    end
  end

  // Zero-wait APB slave: answer in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= psel && !penable;
      pslverr_reg <= psel && !penable && !known;
      prdata_reg  <= '0;
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          ERF_ADDR_RXFC:   prdata_reg <= receive_filter_config_reg;
          ERF_ADDR_CTRL:   prdata_reg <= mac_main_control_reg;
          ERF_ADDR_STA_LO: prdata_reg <= station_addr_reg[31:0];
          ERF_ADDR_STA_HI: prdata_reg <= {16'h0000, station_addr_reg[47:32]};
          ERF_ADDR_ACCCNT: prdata_reg <= accept_count_reg;
          ERF_ADDR_REJCNT: prdata_reg <= reject_count_reg;
          ERF_ADDR_STATUS: prdata_reg <= {29'h0000_0000, cfg_write_refused_reg,
                                          verdict_valid_reg, fifo_out_valid};
          default:         prdata_reg <= '0;
        endcase
      end
    end
  end

  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign verdict_valid  = verdict_valid_reg;
  assign verdict        = verdict_reg;
  assign receive_enable = receive_enable_reg;
endmodule
`default_nettype wire

/* File: dv/erf_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module erf_sva
  import erf_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic  [11:0] paddr,
  input wire logic  [31:0] pwdata,
  input wire logic  [31:0] prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         desc_ready,
  input wire logic         verdict_valid,
  input wire logic         verdict_ready,
  input wire erf_verdict_t verdict,
  input wire logic         receive_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       [9:0] cfg_reg;
  wire logic        acc = psel && penable && pready;
  wire logic        wr_receive_enable = pwdata[ERF_BIT_RECEIVE_ENABLE];
  // Shadow of the filter settings, kept only while receive is off
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cfg_reg <= '0;
    else if (acc && pwrite && paddr == ERF_ADDR_RXFC && !receive_enable)
      cfg_reg <= pwdata[9:0];
  ready_timing_a: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_unmapped_a: assert property
    (psel && penable && paddr > ERF_ADDR_STATUS |-> pslverr && pready)
    else $error("unmapped access without pslverr");
  verdict_hold_a:
    assert property (verdict_valid && !verdict_ready
      |=> verdict_valid && $stable(verdict))
    else $error("verdict dropped before taken");
  runt_reject_a:
    assert property (verdict_valid && cfg_reg[4]
      |-> !(verdict.accept && verdict.length < ERF_RUNT_BYTES))
    else $error("short frame accepted");
  cfg_guard_a:
    assert property (acc && !pwrite && paddr == ERF_ADDR_RXFC
      |-> prdata == {22'h0, cfg_reg})
    else $error("filter settings changed while receiving");
  enable_copy_a:
    assert property (acc && pwrite && paddr == ERF_ADDR_CTRL
      |=> receive_enable == $past(wr_receive_enable))
    else $error("receive enable not updated");
  verdict_gate_a:
    assert property ($rose(verdict_valid) |-> $past(receive_enable))
    else $error("verdict while receive disabled");
  cover property (!desc_ready);
  cover property (verdict_valid && verdict.accept);
  cover property (acc && pwrite && paddr == ERF_ADDR_RXFC && receive_enable);
endmodule
bind erf_filter erf_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .desc_ready, .verdict_valid,
  .verdict_ready, .verdict, .receive_enable);
`default_nettype wire

/* File: dv/erf_phy_model.sv */
`timescale 1ns/1ns
`default_nettype none
module erf_phy_model
  import erf_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      desc_valid,
  input  wire logic desc_ready,
  output erf_desc_t desc
);
  erf_desc_t q[$];
  initial desc_valid = 1'b0;
  initial desc = '0;
  // Idle bus toggles so a stale frame never looks valid
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      desc_valid <= 1'b0;
    else if (!desc_valid || desc_ready)
    begin
      desc_valid <= q.size() > 0;
      desc <= (q.size() > 0) ? q.pop_front() : ~desc;
    end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import erf_pkg::*;
;
  localparam logic [47:0] STA = 48'h0200_1234_5678;
  localparam logic [31:0] RX_ON = 32'h0000_0001 << ERF_BIT_RECEIVE_ENABLE;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic         verdict_ready = 1'b1;
  logic  [11:0] paddr = '0;
  logic  [31:0] pwdata = '0;
  logic  [31:0] prdata, rd, e;
  logic         pready, pslverr, err, desc_valid, desc_ready;
  logic         verdict_valid, receive_enable;
  erf_desc_t    desc;
  erf_verdict_t verdict, vq[$];
  int           failures = 0, n_tests = 0, cyc = 0, nacc = 0, nrej = 0;
  logic   [9:0] ct[12] = '{10'h008, 10'h004, 10'h002, 10'h001, 10'h300,
    10'h000, 10'h08F, 10'h04F, 10'h02F, 10'h06F, 10'h0CF, 10'h01F};
  erf_desc_t    dt[8] = '{'{STA, 16'h0040, 1'b1, 1'b0, 1'b0},
    '{48'h0200_0000_0001, 16'h0200, 1'b1, 1'b0, 1'b0},
    '{48'h0100_5E00_0001, 16'h0080, 1'b1, 1'b0, 1'b0},
    '{ERF_BCAST, 16'h0040, 1'b1, 1'b0, 1'b0},
    '{STA, 16'h003F, 1'b1, 1'b0, 1'b0},
    '{STA, 16'h003F, 1'b0, 1'b0, 1'b0},
    '{48'h0200_0000_0003, 16'h0100, 1'b0, 1'b0, 1'b1},
    '{48'h0200_0000_0002, 16'h0100, 1'b1, 1'b1, 1'b0}};
  always #5 pclk = ~pclk;
  erf_filter uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .desc_valid, .desc_ready, .desc,
    .verdict_valid, .verdict_ready, .verdict, .receive_enable);
  erf_phy_model phy (.pclk, .presetn, .desc_valid, .desc_ready, .desc);
  always @(posedge pclk)
  begin
    if (verdict_valid && verdict_ready)
      vq.push_back(verdict);
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      summarize();
    end
  end
  function automatic logic acc_exp(logic [9:0] c, erf_desc_t d);
    logic r, rc, u, q, a;
    r = d.length < ERF_RUNT_BYTES;
    rc = r && (d.crc_ok || !c[6]);
    u = !d.dest[40];
    q = !(c[7] && d.crc_ok);
    q = q && !(c[6] && !d.crc_ok);
    q = q && !(c[5] && !rc);
    q = q && !(c[4] && r);
    a = c[3] && u && d.dest == STA;
    a = a || (c[2] && u && d.dest != STA);
    a = a || (c[1] && !u && d.dest != ERF_BCAST);
    a = a || (c[0] && d.dest == ERF_BCAST);
    a = a || d.hash_hit;
    a = a || d.wake_hit;
    return q && a;
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, x, g);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ERF_ADDR_RXFC, 0);
    chk("rxfc reset", ERF_RXFC_RST, rd);
    apb(0, ERF_ADDR_CTRL, 0);
    chk("ctrl reset", 32'h0000_0000, rd);
    apb(0, 12'h01C, 0);
    chk("slverr", 32'h0000_0001, {31'h0, err});
    $display("test reset done");
    apb(1, ERF_ADDR_STA_LO, STA[31:0]);
    apb(1, ERF_ADDR_STA_HI, {16'h0, STA[47:32]});
    foreach (ct[i])
    begin
      apb(1, ERF_ADDR_RXFC, {22'h0, ct[i]});
      apb(1, ERF_ADDR_CTRL, RX_ON);
      foreach (dt[j])
        phy.q.push_back(dt[j]);
      while (vq.size() < 8)
        @(posedge pclk);
      foreach (dt[j])
      begin
        e = {15'h0, acc_exp(ct[i], dt[j]), dt[j].length};
        chk("verdict", e, {15'h0, vq[j]});
        if (e[16]) nacc++;
        else nrej++;
      end
      vq.delete();
      apb(1, ERF_ADDR_CTRL, 0);
    end
    $display("test filter table done");
    apb(1, ERF_ADDR_CTRL, RX_ON);
    apb(1, ERF_ADDR_RXFC, 32'h0000_00FF);
    apb(0, ERF_ADDR_RXFC, 0);
    chk("rxfc kept", {22'h0, ct[11]}, rd);
    apb(0, ERF_ADDR_STATUS, 0);
    chk("status refused", 32'h0000_0004, rd);
    $display("test guarded write done");
    apb(1, ERF_ADDR_CTRL, 0);
    verdict_ready <= 1'b0;
    repeat (6) phy.q.push_back(dt[0]);
    do @(posedge pclk); while (desc_ready);
    apb(0, ERF_ADDR_STATUS, 0);
    chk("status full", 32'h0000_0005, rd);
    apb(1, ERF_ADDR_CTRL, RX_ON);
    while (!verdict_valid)
      @(posedge pclk);
    apb(0, ERF_ADDR_STATUS, 0);
    chk("status stalled", 32'h0000_0007, rd);
    verdict_ready <= 1'b1;
    while (vq.size() < 6)
      @(posedge pclk);
    nacc += 6;
    apb(0, ERF_ADDR_ACCCNT, 0);
    chk("accepts", nacc, rd);
    apb(0, ERF_ADDR_REJCNT, 0);
    chk("rejects", nrej, rd);
    apb(1, ERF_ADDR_CTRL, 0);
    apb(1, ERF_ADDR_RXFC, 32'h0000_000F);
    apb(0, ERF_ADDR_STATUS, 0);
    chk("status clear", 32'h0000_0000, rd);
    $display("test buffer done");
    summarize();
  end
endmodule
`default_nettype wire
